//--- rtl/drs_top.sv
// Summary of operation
// - low external pin resets; short pulses filtered
// - pin never driven; input only
// - pin disabled becomes plain digital input
// - power-on clears power flag; never hardware-set
// - two-bit field picks brown-out power mode
// - brown-out resets device without re-arming power-on
// - zero-power mode re-arms power-on; no reset until supply recovers, then power-on reset
// - enable config off, software, awake, always
// - software enable acts only in config 01
// - trip level from configuration only
// - brown-out flag cleared on brown-out, or on power-on while detector enabled
// - config 10 disables detection during sleep
// - shadow mismatch resets and clears mismatch flag
// - hard resets reload configuration words
// - 11-bit power-up timer holds reset
// - power-up timer runs only when enable low
// - power-up timer first, then oscillator timer
// - crystal modes wait 1024 oscillator cycles
// - PLL lock time-out follows oscillator timer
`timescale 1ns/1ps
module drs_top #(
    parameter int PIN_FILTER = drs_pkg::PIN_FILTER_CYCLES,
    parameter int POWERUP_TIMER_LEN = drs_pkg::POWERUP_TIMER_TICKS,
    parameter int OST_LEN = drs_pkg::OST_CYCLES,
    parameter int PLL_LEN = drs_pkg::PLL_LOCK_CYCLES,
    parameter int OSC_DIV = drs_pkg::OSC_DIV_CYCLES
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ext_reset_n_pin, // External reset pin level
    input wire logic porDetect, // Power-on detector, high = pulse
    input wire logic brownoutDetect, // Supply below trip level
    input wire logic watchdogReset, // Watchdog reset pulse
    input wire logic sleepMode, // Device is in sleep
    input wire drs_pkg::drs_cfg_t nvmConfig, // Configuration words in memory
    input wire drs_pkg::drs_cfg_t nvmShadow, // Complementary shadow copy
    output logic coreReset, // Core held in reset
    output logic extPinOe, // Pin output enable
    output logic extPinIn, // Pin as digital input
    output logic brownoutEnable, // Detector enable
    output logic [1:0] brownoutPower, // Detector power mode
    output logic [1:0] brownoutLevel // Detector trip level
);
    drs_pkg::drs_state_t state_q;
    drs_pkg::drs_state_t state_d;
    drs_pkg::drs_cfg_t cfg_q;
    logic cfgValid_q;
    logic powerUp_q;
    logic rearm_q;
    logic swEn_q;
    logic cmFlag_q;
    logic pwrFlag_q;
    logic bodFlag_q;
    logic bodEn_q;
    logic coreReset_q;
    logic extPinOe_q;
    logic extPinIn_q;
    logic [1:0] bodPower_q;
    logic [1:0] bodLevel_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [15:0] oscDiv_q;

    logic pinLevel;
    logic pinLow;
    logic bodSync;
    logic porSync;
    logic pwrtDone;
    logic ostDone;
    logic pllDone;

    drs_pin_filter #(.CYCLES(PIN_FILTER), .WIDTH(8)) u_pin (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinRaw(ext_reset_n_pin),
        .level(pinLevel),
        .lowSeen(pinLow)
    );

    drs_pin_filter #(.CYCLES(1), .WIDTH(2)) u_bod (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinRaw(!brownoutDetect),
        .level(),
        .lowSeen(bodSync)
    );

    drs_pin_filter #(.CYCLES(1), .WIDTH(2)) u_por (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinRaw(!porDetect),
        .level(),
        .lowSeen(porSync)
    );

    // Internal oscillator rate as a one-cycle enable
    wire oscTick = (oscDiv_q == 16'(OSC_DIV - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscDiv_q <= 16'h0000;
        end else begin
            oscDiv_q <= oscTick ? 16'h0000 : oscDiv_q + 16'h0001;
        end
    end

    // Reset sources
    wire pinRst = pinLow && cfg_q.pinEnable;
    wire zeroMode = (cfg_q.powerSel == drs_pkg::BOD_PWR_ZERO);
    wire bodActive = bodSync && bodEn_q;
    wire borRst = bodActive && !zeroMode;
    wire rearmFire = rearm_q && !bodSync;
    wire porEvt = porSync || rearmFire;
    // No compare while held or loading: the stale copy would keep the sequence in reset forever
    wire cmArmed = cfgValid_q && (state_q != drs_pkg::ST_HOLD) && (state_q != drs_pkg::ST_LOAD);
    wire cmRst = cmArmed && (cfg_q != ~nvmShadow);
    wire holdSrc = pinRst || borRst || porSync;
    wire anyRst = holdSrc || rearmFire || watchdogReset || cmRst;

    // Detector enable from the enable configuration
    wire cfgSw = (cfg_q.enableCfg == drs_pkg::BOD_EN_SW);
    wire bodEn_d = (cfg_q.enableCfg == drs_pkg::BOD_EN_ON) ||
        ((cfg_q.enableCfg == drs_pkg::BOD_EN_AWAKE) && !sleepMode) ||
        (cfgSw && swEn_q);

    // Release sequence
    // The words load on the edge that leaves ST_LOAD, so that state decides from memory
    wire drs_pkg::drs_cfg_t seqCfg = (state_q == drs_pkg::ST_LOAD) ? nvmConfig : cfg_q;
    wire goPwrt = powerUp_q && !seqCfg.pwrtDisableN;
    wire goOst = powerUp_q && seqCfg.oscCrystal;
    wire goPll = powerUp_q && seqCfg.pllEnable;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            drs_pkg::ST_HOLD: begin
                if (!holdSrc) begin
                    state_d = drs_pkg::ST_LOAD;
                end
            end
            drs_pkg::ST_LOAD: begin
                if (goPwrt) begin
                    state_d = drs_pkg::ST_POWERUP_TIMER;
                end else if (goOst) begin
                    state_d = drs_pkg::ST_OST;
                end else if (goPll) begin
                    state_d = drs_pkg::ST_PLL;
                end else begin
                    state_d = drs_pkg::ST_RUN;
                end
            end
            drs_pkg::ST_POWERUP_TIMER: begin
                if (pwrtDone) begin
                    state_d = goOst ? drs_pkg::ST_OST : (goPll ? drs_pkg::ST_PLL : drs_pkg::ST_RUN);
                end
            end
            drs_pkg::ST_OST: begin
                if (ostDone) begin
                    state_d = goPll ? drs_pkg::ST_PLL : drs_pkg::ST_RUN;
                end
            end
            drs_pkg::ST_PLL: begin
                if (pllDone) begin
                    state_d = drs_pkg::ST_RUN;
                end
            end
            drs_pkg::ST_RUN: begin
                state_d = drs_pkg::ST_RUN;
            end
        endcase
        if (anyRst) begin
            state_d = drs_pkg::ST_HOLD;
        end
    end

    drs_timer #(.LIMIT(POWERUP_TIMER_LEN), .WIDTH(drs_pkg::POWERUP_TIMER_WIDTH)) u_powerup_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(state_q == drs_pkg::ST_POWERUP_TIMER),
        .tick(oscTick),
        .done(pwrtDone)
    );

    drs_timer #(.LIMIT(OST_LEN), .WIDTH(11)) u_ost (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(state_q == drs_pkg::ST_OST),
        .tick(1'b1),
        .done(ostDone)
    );

    drs_timer #(.LIMIT(PLL_LEN), .WIDTH(17)) u_pll (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(state_q == drs_pkg::ST_PLL),
        .tick(1'b1),
        .done(pllDone)
    );

    // APB decode; one wait state so that read data come from a register
    wire apbAcc = psel && penable && !pready_q;
    wire selCtrl = (paddr == drs_pkg::ADDR_RESET_CTRL);
    wire selCfg = (paddr == drs_pkg::ADDR_CONFIG);
    wire selState = (paddr == drs_pkg::ADDR_STATE);
    wire mapped = selCtrl || selCfg || selState;
    wire ctrlWr = apbAcc && pwrite && selCtrl;
    wire swEnView = swEn_q && cfgSw;
    wire [31:0] ctrlView = {25'h0, swEnView, cmFlag_q, 3'h0, pwrFlag_q, bodFlag_q};
    wire [31:0] cfgView = {22'h0, cfg_q};
    wire [31:0] stateView = {24'h000000, bodEn_q, cfgValid_q, state_q};
    wire [31:0] rdMux = selCtrl ? ctrlView : (selCfg ? cfgView : (selState ? stateView : 32'h0));

    // Flag and enable updates: a hardware clear, or the power-on reload of the software enable, wins over a software write
    wire pwrFlag_d = porEvt ? 1'b0 : (ctrlWr ? pwdata[drs_pkg::BIT_PWR] : pwrFlag_q);
    wire bodFlag_d = (bodEn_q && (borRst || porEvt)) ? 1'b0 :
        (ctrlWr ? pwdata[drs_pkg::BIT_BOD] : bodFlag_q);
    wire cmFlag_d = cmRst ? 1'b0 : (ctrlWr ? pwdata[drs_pkg::BIT_CM] : cmFlag_q);
    wire swEn_d = porEvt ? drs_pkg::RST_SW_EN : (ctrlWr ? pwdata[drs_pkg::BIT_SW_EN] : swEn_q);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwrFlag_q <= drs_pkg::RST_PWR;
            bodFlag_q <= drs_pkg::RST_BOD;
            cmFlag_q <= drs_pkg::RST_CM;
            swEn_q <= drs_pkg::RST_SW_EN;
        end else begin
            pwrFlag_q <= pwrFlag_d;
            bodFlag_q <= bodFlag_d;
            cmFlag_q <= cmFlag_d;
            swEn_q <= swEn_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= apbAcc;
            pslverr_q <= apbAcc && !mapped;
            prdata_q <= (apbAcc && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    // Configuration reload; a hard or power reset passes ST_LOAD every time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= drs_pkg::CFG_RST;
            cfgValid_q <= 1'b0;
        end else if (state_q == drs_pkg::ST_LOAD) begin
            cfg_q <= nvmConfig;
            cfgValid_q <= 1'b1;
        end
    end

    // Power-up marker and re-arm of the power-on path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            powerUp_q <= 1'b1;
            rearm_q <= 1'b0;
        end else begin
            powerUp_q <= porEvt || (powerUp_q && state_q != drs_pkg::ST_RUN);
            // Recovery counts as power-on only in zero-power mode; brown-out keeps the power flag
            rearm_q <= (bodActive && zeroMode) || (rearm_q && bodSync);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= drs_pkg::ST_HOLD;
            coreReset_q <= 1'b1;
            bodEn_q <= 1'b0;
            extPinOe_q <= 1'b0;
            extPinIn_q <= 1'b1;
            bodPower_q <= drs_pkg::BOD_PWR_HIGH;
            bodLevel_q <= 2'h0;
        end else begin
            state_q <= state_d;
            coreReset_q <= (state_d != drs_pkg::ST_RUN);
            bodEn_q <= bodEn_d;
            extPinOe_q <= 1'b0;
            extPinIn_q <= cfg_q.pinEnable ? 1'b1 : pinLevel;
            bodPower_q <= cfg_q.powerSel;
            bodLevel_q <= cfg_q.levelSel;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign coreReset = coreReset_q;
    assign extPinOe = extPinOe_q;
    assign extPinIn = extPinIn_q;
    assign brownoutEnable = bodEn_q;
    assign brownoutPower = bodPower_q;
    assign brownoutLevel = bodLevel_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_pin_input_only: assert property (extPinOe_q == 1'b0)
        else $error("reset pin output enable went high");
    a_pin_holds_reset: assert property (pinRst |=> coreReset_q && state_q == drs_pkg::ST_HOLD)
        else $error("filtered pin low did not hold reset");
    a_pin_disabled: assert property (!cfg_q.pinEnable |-> !pinRst ##0 extPinIn_q == $past(pinLevel) || $changed(cfg_q))
        else $error("disabled pin still acts as reset");
    a_por_clears_flag: assert property (porEvt |=> !pwrFlag_q)
        else $error("power flag not cleared by power-on");
    a_pwr_no_hw_set: assert property ($rose(pwrFlag_q) |-> $past(ctrlWr) && $past(pwdata[drs_pkg::BIT_PWR]))
        else $error("power flag set without software write");
    a_zero_no_reset: assert property (zeroMode && bodActive && !pinRst
        && !porSync && !watchdogReset && !cmRst && state_q == drs_pkg::ST_RUN
        |=> state_q == drs_pkg::ST_RUN)
        else $error("zero-power mode caused a reset");
    a_bor_flag_clear: assert property (bodEn_q && borRst |=> !bodFlag_q ##1 coreReset_q)
        else $error("brown-out flag not cleared");
    a_sw_en_view: assert property (!cfgSw |-> !swEnView)
        else $error("software enable visible outside config 01");
    a_sleep_disable: assert property ((cfg_q.enableCfg == drs_pkg::BOD_EN_AWAKE) && sleepMode
        && $stable(cfg_q) |=> !bodEn_q)
        else $error("detector on in sleep under config 10");
    a_cm_reset: assert property (cmRst |=> !cmFlag_q && coreReset_q)
        else $error("mismatch did not reset and clear flag");
    a_powerup_timer_holds: assert property (state_q == drs_pkg::ST_POWERUP_TIMER |-> coreReset_q)
        else $error("core released during power-up timer");

    c_pin_reset: cover property (pinRst ##1 !pinRst [*2] ##[1:20] state_q == drs_pkg::ST_RUN);
    c_bor_reset: cover property (borRst ##[1:20] !bodFlag_q);
    c_cm_reset: cover property (cmRst ##1 state_q == drs_pkg::ST_HOLD);
    c_ost_path: cover property (state_q == drs_pkg::ST_OST ##1 state_q == drs_pkg::ST_RUN);
endmodule

//--- rtl/drs_pkg.sv
package drs_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_RESET_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_STATE = 12'h008;

    // Bit positions in reset_control_reg
    localparam int BIT_SW_EN = 6;
    localparam int BIT_CM = 5;
    localparam int BIT_PWR = 1;
    localparam int BIT_BOD = 0;

    // Reset values of the sticky flags and the software enable
    localparam logic RST_SW_EN = 1'b1;
    localparam logic RST_CM = 1'b1;
    localparam logic RST_PWR = 1'b0;
    localparam logic RST_BOD = 1'b0;

    // Brown-out enable configurations
    localparam logic [1:0] BOD_EN_OFF = 2'h0;
    localparam logic [1:0] BOD_EN_SW = 2'h1;
    localparam logic [1:0] BOD_EN_AWAKE = 2'h2;
    localparam logic [1:0] BOD_EN_ON = 2'h3;

    // Brown-out power modes
    localparam logic [1:0] BOD_PWR_HIGH = 2'h0;
    localparam logic [1:0] BOD_PWR_MEDIUM = 2'h1;
    localparam logic [1:0] BOD_PWR_LOW = 2'h2;
    localparam logic [1:0] BOD_PWR_ZERO = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int INTERNAL_OSC_PERIOD_NS = 32000;
    localparam int OSC_DIV_CYCLES = INTERNAL_OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int POWERUP_TIMER_TICKS = 2048;
    localparam int POWERUP_TIMER_WIDTH = 11;
    localparam int OST_CYCLES = 1024;
    localparam int PLL_LOCK_NS = 2000000;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_NS / CLK_PERIOD_NS;
    localparam int PIN_FILTER_CYCLES = 4;

    typedef struct packed {
        logic pinEnable;
        logic pllEnable;
        logic oscCrystal;
        logic [1:0] powerSel;
        logic [1:0] levelSel;
        logic [1:0] enableCfg;
        logic pwrtDisableN;
    } drs_cfg_t;

    localparam drs_cfg_t CFG_RST = 10'h000;

    typedef enum logic [5:0] {
        ST_HOLD = 6'h01,
        ST_LOAD = 6'h02,
        ST_POWERUP_TIMER = 6'h04,
        ST_OST = 6'h08,
        ST_PLL = 6'h10,
        ST_RUN = 6'h20
    } drs_state_t;
endpackage

//--- rtl/drs_pin_filter.sv
`timescale 1ns/1ps
module drs_pin_filter #(
    parameter int CYCLES = 4,
    parameter int WIDTH = 8
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic pinRaw, // Asynchronous level
    output logic level, // Synchronised level
    output logic lowSeen // Low for at least CYCLES cycles
);
    logic meta_q;
    logic sync_q;
    logic [WIDTH-1:0] lowCnt_q;
    logic lowSeen_q;
    wire cntFull = (lowCnt_q == WIDTH'(CYCLES - 1));
    wire [WIDTH-1:0] lowCnt_d = sync_q ? '0 : (cntFull ? lowCnt_q : lowCnt_q + WIDTH'(1));

    // A glitch shorter than CYCLES restarts the count and never reaches lowSeen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            lowCnt_q <= '0;
            lowSeen_q <= 1'b0;
        end else begin
            meta_q <= pinRaw;
            sync_q <= meta_q;
            lowCnt_q <= lowCnt_d;
            lowSeen_q <= !sync_q && (cntFull || lowSeen_q);
        end
    end

    assign level = sync_q;
    assign lowSeen = lowSeen_q;
endmodule

//--- rtl/drs_timer.sv
`timescale 1ns/1ps
module drs_timer #(
    parameter int LIMIT = 1024,
    parameter int WIDTH = 11
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic run, // Count while high, clear while low
    input wire logic tick, // Count enable
    output logic done // Last tick of the interval
);
    logic [WIDTH-1:0] cnt_q;
    wire atEnd = (cnt_q == WIDTH'(LIMIT - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (tick && !atEnd) begin
            cnt_q <= cnt_q + WIDTH'(1);
        end
    end

    assign done = run && tick && atEnd;
endmodule

//--- sim/drs_supply_model.sv
`timescale 1ns/1ps
module drs_supply_model (
    input wire logic mclk, // Clock
    input wire logic pinReq, // Start a low pulse on the pin
    input wire logic [7:0] pinLen, // Pulse length in cycles
    input wire logic porLevel, // Supply rising through the power-on threshold
    input wire logic bodLevel, // Supply under the trip level
    output logic ext_reset_n_pin, // Reset pin, pulled up when released
    output logic porDetect, // Power-on pulse
    output logic brownoutDetect // Brown-out detector output
);
    logic [7:0] lowCnt_q = 8'h00;

    always_ff @(posedge mclk) begin
        if (pinReq) begin
            lowCnt_q <= pinLen;
        end else if (lowCnt_q != 8'h00) begin
            lowCnt_q <= lowCnt_q - 8'h01;
        end
    end

    // Held low for the whole count, then the pull-up takes the pin high again
    assign ext_reset_n_pin = (lowCnt_q == 8'h00);
    assign porDetect = porLevel;
    assign brownoutDetect = bodLevel;
endmodule

//--- sim/tb_drs_top.sv
`timescale 1ns/1ps
module tb_drs_top;
    localparam int POWERUP_TIMER_LEN = 4;
    localparam int OSC_DIV = 4;
    localparam int OST_LEN = 8;
    localparam int PLL_LEN = 8;
    localparam drs_pkg::drs_cfg_t C1 = '{1'b1, 1'b1, 1'b1, drs_pkg::BOD_PWR_HIGH, 2'h2,
        drs_pkg::BOD_EN_SW, 1'b0};
    localparam drs_pkg::drs_cfg_t C2 = '{1'b1, 1'b0, 1'b0, drs_pkg::BOD_PWR_LOW, 2'h1,
        drs_pkg::BOD_EN_AWAKE, 1'b1};
    localparam drs_pkg::drs_cfg_t C3 = '{1'b0, 1'b0, 1'b1, drs_pkg::BOD_PWR_ZERO, 2'h3,
        drs_pkg::BOD_EN_ON, 1'b1};
    localparam drs_pkg::drs_cfg_t C4 = '{1'b1, 1'b0, 1'b0, drs_pkg::BOD_PWR_MEDIUM, 2'h0,
        drs_pkg::BOD_EN_OFF, 1'b1};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, lastErr, extPin, porDetect, brownoutDetect;
    logic pinReq = 1'b0, porLevel = 1'b0, bodLevel = 1'b0, watchdogReset = 1'b0;
    logic sleepMode = 1'b0;
    logic [7:0] pinLen = 8'h00;
    logic coreReset, extPinOe, extPinIn, brownoutEnable;
    logic [1:0] brownoutPower, brownoutLevel;
    drs_pkg::drs_cfg_t cfg = C1;
    drs_pkg::drs_cfg_t shadow = drs_pkg::drs_cfg_t'(~C1);
    logic sawReset = 1'b0, sawOe = 1'b0;
    int fails = 0, comparisons = 0, n;

    drs_top #(.POWERUP_TIMER_LEN(POWERUP_TIMER_LEN), .OST_LEN(OST_LEN), .PLL_LEN(PLL_LEN), .OSC_DIV(OSC_DIV))
    drs_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n_pin(extPin), .porDetect(porDetect), .brownoutDetect(brownoutDetect),
        .watchdogReset(watchdogReset), .sleepMode(sleepMode), .nvmConfig(cfg),
        .nvmShadow(shadow), .coreReset(coreReset), .extPinOe(extPinOe), .extPinIn(extPinIn),
        .brownoutEnable(brownoutEnable), .brownoutPower(brownoutPower),
        .brownoutLevel(brownoutLevel));

    drs_supply_model drs_supply_model_inst (.mclk(mclk), .pinReq(pinReq), .pinLen(pinLen),
        .porLevel(porLevel), .bodLevel(bodLevel), .ext_reset_n_pin(extPin),
        .porDetect(porDetect), .brownoutDetect(brownoutDetect));

    initial begin
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (coreReset === 1'b1) sawReset <= 1'b1;
        if (extPinOe !== 1'b0) sawOe <= 1'b1;
    end

    task automatic close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one edge after release
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 20) fails++;
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] mask,
        input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd & mask, exp);
    endtask

    task automatic wait_core(input logic lvl);
        n = 0;
        while (coreReset !== lvl && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) fails++;
    endtask

    // New words in memory and shadow differ from the loaded copy, so a mismatch reset reloads
    task automatic reconf(input drs_pkg::drs_cfg_t c);
        cfg <= c;
        shadow <= drs_pkg::drs_cfg_t'(~c);
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk(drs_pkg::ADDR_CONFIG, 32'h0000_03FF, {22'h0, c});
        check({28'h0, brownoutPower, brownoutLevel}, {28'h0, c.powerSel, c.levelSel});
    endtask

    task automatic bod_burst(input logic expReset);
        sawReset = 1'b0;
        bodLevel <= 1'b1;
        repeat (10) @(posedge mclk);
        check({31'h0, sawReset}, {31'h0, expReset});
        bodLevel <= 1'b0;
        wait_core(1'b0);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        wait_core(1'b0);
        check({31'h0, n >= POWERUP_TIMER_LEN * OSC_DIV + OST_LEN + PLL_LEN}, 32'h1);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0060);
        rd_chk(drs_pkg::ADDR_STATE, 32'h0000_00FF, 32'h0000_00E0);
        check({30'h0, brownoutLevel}, 32'h2);
        rd_chk(12'h00C, 32'hFFFF_FFFF, 32'h0000_0000);
        check({31'h0, lastErr}, 32'h1);
        apb(1'b1, drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0063);
        // Two-cycle glitch must be filtered, a long low must reset
        sawReset = 1'b0;
        pinReq <= 1'b1;
        pinLen <= 8'h02;
        @(posedge mclk);
        pinReq <= 1'b0;
        repeat (12) @(posedge mclk);
        check({31'h0, sawReset}, 32'h0);
        pinReq <= 1'b1;
        pinLen <= 8'h14;
        @(posedge mclk);
        pinReq <= 1'b0;
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0063);
        watchdogReset <= 1'b1;
        @(posedge mclk);
        watchdogReset <= 1'b0;
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0063);
        bod_burst(1'b1);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0062);
        apb(1'b1, drs_pkg::ADDR_RESET_CTRL, 32'h0000_0023);
        repeat (2) @(posedge mclk);
        check({31'h0, brownoutEnable}, 32'h0);
        bod_burst(1'b0);
        apb(1'b1, drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063);
        reconf(C2);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0063, 32'h0000_0003);
        check({31'h0, brownoutEnable}, 32'h1);
        sleepMode <= 1'b1;
        repeat (3) @(posedge mclk);
        check({31'h0, brownoutEnable}, 32'h0);
        sleepMode <= 1'b0;
        repeat (3) @(posedge mclk);
        check({31'h0, brownoutEnable}, 32'h1);
        reconf(C3);
        sawReset = 1'b0;
        pinReq <= 1'b1;
        pinLen <= 8'h14;
        @(posedge mclk);
        pinReq <= 1'b0;
        repeat (6) @(posedge mclk);
        check({31'h0, extPinIn}, 32'h0);
        repeat (20) @(posedge mclk);
        check({30'h0, sawReset, extPinIn}, 32'h1);
        bod_burst(1'b0);
        wait_core(1'b1);
        wait_core(1'b0);
        check({31'h0, n < POWERUP_TIMER_LEN * OSC_DIV}, 32'h1);
        rd_chk(drs_pkg::ADDR_RESET_CTRL, 32'h0000_0043, 32'h0000_0000);
        reconf(C4);
        check({31'h0, brownoutEnable}, 32'h0);
        bod_burst(1'b0);
        check({31'h0, sawOe}, 32'h0);
        close_out;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out;
    end
endmodule
